// [verilog/cpu_amd_pkg.sv]
/*
 Shared constants and types for the operand-fetch and address unit.
 Assumes a byte-wide program memory with a 13-bit address space.
*/
package cpu_amd_pkg;
	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int ADDR_W = 13;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [7:0] byte_t;
	typedef logic [5:0] instr_idx_t;
	localparam instr_idx_t NUM_INSTR = 6'h3E;
	localparam int NUM_MODES = 8;

	// ----------------------------------------------------------------
	// Addressing modes and instruction lengths
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX, AM_IX1, AM_IX2, AM_REL
	} am_e;
	typedef logic [1:0] len_t;
	localparam len_t LEN_1 = 2'h1;
	localparam len_t LEN_2 = 2'h2;
	localparam len_t LEN_3 = 2'h3;

	// ----------------------------------------------------------------
	// Fixed values
	// ----------------------------------------------------------------
	localparam byte_t ZERO_HI = 8'h00;
	localparam addr_t PC_RST = 13'h0000;
	localparam addr_t PC_STEP = 13'h0001;
	localparam addr_t ADDR_ZERO = 13'h0000;
	localparam byte_t BYTE_ZERO = 8'h00;
endpackage

// [verilog/mul_if.sv]
/*
 Carrier between the address unit and its multiplier.
 Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface mul_if;
	logic [7:0] a;
	logic [7:0] x;
	logic start;
	logic [15:0] prod;
	logic done;
	modport host(output a, output x, output start,
		input prod, input done);
	modport unit(input a, input x, input start,
		output prod, output done);
endinterface

// [verilog/mul_unit.sv]
/*
 Registered 8 by 8 unsigned multiplier.
 Assumes operands are stable in the cycle that start is high.
*/
`timescale 1ns/1ps
module mul_unit (
	input wire logic sys_clk,
	input wire logic reset,
	mul_if.unit m
);
	logic [15:0] prod_ff;
	logic done_ff;

	// ----------------------------------------------------------------
	// Product register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prod_ff <= 16'h0000;
			done_ff <= 1'b0;
		end else begin
			done_ff <= m.start;
			if (m.start) begin
				prod_ff <= {8'h00, m.a} * {8'h00, m.x};
			end
		end
	end

	assign m.prod = prod_ff;
	assign m.done = done_ff;
endmodule

// [verilog/cpu_addr_decode.sv]
/*
 Operand fetch and effective address generation for an 8-bit CPU.
 Assumes memory read data arrive the cycle after mem_rd_ff, and that
 the opcode table answers mode, index and flags from opcode_ff.
*/
`timescale 1ns/1ps

// What this block does
// - Only 62 instructions; others flagged illegal.
// - Multiply A by X; high to X.
// - Inherent is one byte, no address.
// - Immediate is two bytes, literal operand.
// - Direct uses byte two, high zero.
// - Extended is three bytes, high first.
// - Indexed no offset uses X, high zero.
// - Indexed 8-bit offset adds X unwrapped.
// - Indexed 16-bit offset adds X, high first.
// - Taken branch adds signed offset to PC.
// - Untaken branch continues at next instruction.
// - Offset spans -128..+127 from next address.
module cpu_addr_decode (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic go,
	input wire logic pc_load,
	input wire cpu_amd_pkg::addr_t pc_in,
	input wire cpu_amd_pkg::byte_t mem_rdata,
	input wire cpu_amd_pkg::am_e mode_in,
	input wire cpu_amd_pkg::instr_idx_t instr_idx,
	input wire logic is_mul,
	input wire logic br_cond,
	input wire cpu_amd_pkg::byte_t acc_in,
	input wire cpu_amd_pkg::byte_t idx_in,
	output cpu_amd_pkg::addr_t mem_addr_ff,
	output logic mem_rd_ff,
	output cpu_amd_pkg::byte_t opcode_ff,
	output cpu_amd_pkg::byte_t imm_ff,
	output logic imm_vld_ff,
	output cpu_amd_pkg::addr_t ea_ff,
	output logic ea_vld_ff,
	output cpu_amd_pkg::addr_t pc_ff,
	output cpu_amd_pkg::byte_t acc_out_ff,
	output cpu_amd_pkg::byte_t idx_out_ff,
	output logic ax_wr_ff,
	output logic illegal_ff,
	output logic done_ff,
	output logic busy_ff
);
	import cpu_amd_pkg::*;

	// ----------------------------------------------------------------
	// State and operand registers
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_OPC, S_CAP, S_MODE, S_RD1, S_CAP1,
		S_RD2, S_CAP2, S_MUL, S_EXEC
	} st_e;

	st_e st_ff;
	am_e mode_ff;
	len_t len_ff;
	byte_t b1_ff;
	byte_t b2_ff;
	logic mul_go_ff;

	mul_if mi();

	mul_unit u_mul (
		.sys_clk(sys_clk),
		.reset(reset),
		.m(mi.unit)
	);

	// ----------------------------------------------------------------
	// Decode and address arithmetic
	// ----------------------------------------------------------------
	wire len_t len_dec;
	wire logic idx_bad;
	wire logic [15:0] ofs16;
	wire logic [8:0] sum9;
	wire logic [15:0] sum16;
	wire addr_t ea_dir;
	wire addr_t ea_ext;
	wire addr_t ea_ix;
	wire addr_t ea_ix1;
	wire addr_t ea_ix2;
	wire addr_t rel_ofs;
	wire addr_t rel_tgt;
	wire addr_t pc_inc;
	wire logic mem_mode;
	wire addr_t ea_sel;

	assign len_dec = (mode_in == AM_INH || mode_in == AM_IX) ? LEN_1 :
		(mode_in == AM_EXT || mode_in == AM_IX2) ? LEN_3 : LEN_2;
	assign idx_bad = instr_idx >= NUM_INSTR;
	assign ofs16 = {b1_ff, b2_ff};
	assign sum9 = {1'b0, b1_ff} + {1'b0, idx_in};
	assign sum16 = ofs16 + {ZERO_HI, idx_in};
	assign ea_dir = addr_t'({ZERO_HI, b1_ff});
	assign ea_ext = ofs16[ADDR_W-1:0];
	assign ea_ix = addr_t'({ZERO_HI, idx_in});
	assign ea_ix1 = addr_t'(sum9);
	assign ea_ix2 = sum16[ADDR_W-1:0];
	assign rel_ofs = addr_t'({{(ADDR_W-8){b1_ff[7]}}, b1_ff});
	assign rel_tgt = pc_ff + rel_ofs;
	assign pc_inc = pc_ff + PC_STEP;
	assign mem_mode = mode_ff == AM_DIR || mode_ff == AM_EXT ||
		mode_ff == AM_IX || mode_ff == AM_IX1 || mode_ff == AM_IX2;
	assign ea_sel = (mode_ff == AM_DIR) ? ea_dir :
		(mode_ff == AM_EXT) ? ea_ext :
		(mode_ff == AM_IX) ? ea_ix :
		(mode_ff == AM_IX1) ? ea_ix1 : ea_ix2;

	assign mi.a = acc_in;
	assign mi.x = idx_in;
	assign mi.start = mul_go_ff;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// The PC is bumped as each byte lands, so at S_EXEC it already
	// points past the instruction; branch offsets need no correction.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= S_IDLE;
			mode_ff <= AM_INH;
			len_ff <= LEN_1;
			b1_ff <= BYTE_ZERO;
			b2_ff <= BYTE_ZERO;
			mul_go_ff <= 1'b0;
			mem_addr_ff <= ADDR_ZERO;
			mem_rd_ff <= 1'b0;
			opcode_ff <= BYTE_ZERO;
			imm_ff <= BYTE_ZERO;
			imm_vld_ff <= 1'b0;
			ea_ff <= ADDR_ZERO;
			ea_vld_ff <= 1'b0;
			pc_ff <= PC_RST;
			acc_out_ff <= BYTE_ZERO;
			idx_out_ff <= BYTE_ZERO;
			ax_wr_ff <= 1'b0;
			illegal_ff <= 1'b0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			mem_rd_ff <= 1'b0;
			mul_go_ff <= 1'b0;
			imm_vld_ff <= 1'b0;
			ea_vld_ff <= 1'b0;
			ax_wr_ff <= 1'b0;
			illegal_ff <= 1'b0;
			done_ff <= 1'b0;
			case (st_ff)
			S_IDLE: begin
				if (pc_load) begin
					pc_ff <= pc_in;
				end else if (go) begin
					mem_addr_ff <= pc_ff;
					mem_rd_ff <= 1'b1;
					busy_ff <= 1'b1;
					st_ff <= S_OPC;
				end
			end
			S_OPC: st_ff <= S_CAP;
			S_CAP: begin
				opcode_ff <= mem_rdata;
				pc_ff <= pc_inc;
				st_ff <= S_MODE;
			end
			S_MODE: begin
				mode_ff <= mode_in;
				len_ff <= len_dec;
				if (idx_bad) begin
					illegal_ff <= 1'b1;
					done_ff <= 1'b1;
					busy_ff <= 1'b0;
					st_ff <= S_IDLE;
				end else if (is_mul) begin
					mul_go_ff <= 1'b1;
					st_ff <= S_MUL;
				end else if (len_dec == LEN_1) begin
					st_ff <= S_EXEC;
				end else begin
					mem_addr_ff <= pc_ff;
					mem_rd_ff <= 1'b1;
					st_ff <= S_RD1;
				end
			end
			S_RD1: st_ff <= S_CAP1;
			S_CAP1: begin
				b1_ff <= mem_rdata;
				pc_ff <= pc_inc;
				if (len_ff == LEN_3) begin
					mem_addr_ff <= pc_inc;
					mem_rd_ff <= 1'b1;
					st_ff <= S_RD2;
				end else begin
					st_ff <= S_EXEC;
				end
			end
			S_RD2: st_ff <= S_CAP2;
			S_CAP2: begin
				b2_ff <= mem_rdata;
				pc_ff <= pc_inc;
				st_ff <= S_EXEC;
			end
			S_MUL: begin
				if (mi.done) begin
					idx_out_ff <= mi.prod[15:8];
					acc_out_ff <= mi.prod[7:0];
					ax_wr_ff <= 1'b1;
					done_ff <= 1'b1;
					busy_ff <= 1'b0;
					st_ff <= S_IDLE;
				end
			end
			S_EXEC: begin
				imm_ff <= b1_ff;
				imm_vld_ff <= mode_ff == AM_IMM;
				ea_ff <= ea_sel;
				ea_vld_ff <= mem_mode;
				if (mode_ff == AM_REL && br_cond) begin
					pc_ff <= rel_tgt;
				end
				done_ff <= 1'b1;
				busy_ff <= 1'b0;
				st_ff <= S_IDLE;
			end
			default: st_ff <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_instr_count: assert property (
		@(posedge sys_clk) disable iff (reset)
		illegal_ff |-> $past(instr_idx) >= NUM_INSTR)
		else $error("illegal flagged for a valid index");

	chk_mul_split: assert property (
		@(posedge sys_clk) disable iff (reset)
		ax_wr_ff |-> {idx_out_ff, acc_out_ff} ==
			{ZERO_HI, $past(acc_in, 2)} * {ZERO_HI, $past(idx_in, 2)})
		else $error("multiply result misplaced");

	chk_inh_nofetch: assert property (
		@(posedge sys_clk) disable iff (reset)
		(st_ff == S_MODE && mode_in == AM_INH && !is_mul && !idx_bad)
		|=> !mem_rd_ff ##1 done_ff && !ea_vld_ff)
		else $error("inherent instruction fetched an operand");

	chk_imm_value: assert property (
		@(posedge sys_clk) disable iff (reset)
		imm_vld_ff |-> mode_ff == AM_IMM && !ea_vld_ff &&
			imm_ff == $past(mem_rdata, 2))
		else $error("immediate value wrong");

	chk_dir_page: assert property (
		@(posedge sys_clk) disable iff (reset)
		(ea_vld_ff && mode_ff == AM_DIR) |->
			ea_ff == addr_t'({ZERO_HI, $past(mem_rdata, 2)}))
		else $error("direct address wrong");

	chk_ext_order: assert property (
		@(posedge sys_clk) disable iff (reset)
		(ea_vld_ff && mode_ff == AM_EXT) |-> ea_ff ==
			addr_t'({$past(mem_rdata, 4), $past(mem_rdata, 2)}))
		else $error("extended address wrong");

	chk_ix_zero: assert property (
		@(posedge sys_clk) disable iff (reset)
		(ea_vld_ff && mode_ff == AM_IX) |->
			ea_ff == addr_t'({ZERO_HI, $past(idx_in)}))
		else $error("indexed address wrong");

	chk_ix1_sum: assert property (
		@(posedge sys_clk) disable iff (reset)
		(ea_vld_ff && mode_ff == AM_IX1) |-> ea_ff ==
			addr_t'({1'b0, $past(mem_rdata, 2)} + {1'b0, $past(idx_in)}))
		else $error("indexed 8-bit offset address wrong");

	chk_ix2_trunc: assert property (
		@(posedge sys_clk) disable iff (reset)
		(ea_vld_ff && mode_ff == AM_IX2) |-> ea_ff ==
			addr_t'({$past(mem_rdata, 4), $past(mem_rdata, 2)} +
			{ZERO_HI, $past(idx_in)}))
		else $error("indexed 16-bit offset address wrong");

	chk_rel_taken: assert property (
		@(posedge sys_clk) disable iff (reset)
		(done_ff && mode_ff == AM_REL && $past(br_cond) &&
			$past(st_ff) == S_EXEC) |-> pc_ff == $past(pc_ff) +
			addr_t'({{(ADDR_W-8){$past(b1_ff[7])}}, $past(b1_ff)}))
		else $error("branch target wrong");

	chk_rel_skip: assert property (
		@(posedge sys_clk) disable iff (reset)
		(done_ff && mode_ff == AM_REL && !$past(br_cond) &&
			$past(st_ff) == S_EXEC) |-> pc_ff == $past(pc_ff))
		else $error("untaken branch moved the PC");
endmodule

// [bench/mem_model.sv]
/*
 Behavioural model of the program and data memory bus.
 Assumes the read strobe is answered with data one cycle later.
*/
`timescale 1ns/1ps
module mem_model (
	input wire logic sys_clk,
	input wire logic rd,
	input wire cpu_amd_pkg::addr_t addr,
	output cpu_amd_pkg::byte_t rdata
);
	import cpu_amd_pkg::*;
	// ----------------------------------------------------------------
	// Storage and read port
	// ----------------------------------------------------------------
	byte_t ram [0:(1<<ADDR_W)-1];
	initial rdata = 8'h00;
	// Outside an answer the bus shows the inverse of its last value.
	// A design that samples late then sees wrong data, not lucky data.
	always @(posedge sys_clk) begin
		if (rd) begin
			rdata <= ram[addr];
		end else begin
			rdata <= ~rdata;
		end
	end
endmodule

// [bench/cpu_addressing_mode_decode_test.sv]
/*
 Self-checking bench for the operand fetch and address unit.
 Assumes the memory model answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module cpu_addressing_mode_decode_test;
	import cpu_amd_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic go = 1'b0, pc_load = 1'b0, is_mul = 1'b0, br_cond = 1'b0;
	addr_t pc_in = ADDR_ZERO;
	byte_t mem_rdata, acc_in = BYTE_ZERO, idx_in = BYTE_ZERO;
	am_e mode_in = AM_INH;
	instr_idx_t instr_idx = 6'h00;
	addr_t mem_addr_ff, ea_ff, pc_ff;
	byte_t opcode_ff, imm_ff, acc_out_ff, idx_out_ff;
	logic mem_rd_ff, imm_vld_ff, ea_vld_ff, ax_wr_ff;
	logic illegal_ff, done_ff, busy_ff;
	int n_mismatch = 0;
	int tests_run = 0;

	cpu_addr_decode uut (.sys_clk, .reset, .go, .pc_load, .pc_in,
		.mem_rdata, .mode_in, .instr_idx, .is_mul, .br_cond, .acc_in,
		.idx_in, .mem_addr_ff, .mem_rd_ff, .opcode_ff, .imm_ff,
		.imm_vld_ff, .ea_ff, .ea_vld_ff, .pc_ff, .acc_out_ff,
		.idx_out_ff, .ax_wr_ff, .illegal_ff, .done_ff, .busy_ff);
	mem_model mem (.sys_clk(sys_clk), .rd(mem_rd_ff),
		.addr(mem_addr_ff), .rdata(mem_rdata));

	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic cmp_a(input addr_t got, input addr_t exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic cmp_b(input byte_t got, input byte_t exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Expectations
	// ----------------------------------------------------------------
	// An unknown index is refused as soon as it is decoded, and the
	// multiplier answers one cycle after its start, so neither takes
	// the full one-byte path.
	function automatic byte_t exp_len(am_e m, logic mul, instr_idx_t i);
		if (i >= NUM_INSTR) begin
			return 8'h03;
		end
		if (mul) begin
			return 8'h05;
		end
		if (m == AM_INH || m == AM_IX) begin
			return 8'h04;
		end
		if (m == AM_EXT || m == AM_IX2) begin
			return 8'h08;
		end
		return 8'h06;
	endfunction

	function automatic addr_t exp_ea(am_e m, byte_t x, byte_t b2, byte_t b3);
		case (m)
			AM_DIR: return {5'h00, b2};
			AM_EXT: return addr_t'({b2, b3});
			AM_IX: return {5'h00, x};
			AM_IX1: return addr_t'({1'b0, x} + {1'b0, b2});
			AM_IX2: return addr_t'({b2, b3} + {8'h00, x});
			default: return ADDR_ZERO;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// One instruction from a loaded PC, checked at completion
	// ----------------------------------------------------------------
	task automatic run(input am_e m, input instr_idx_t i, input logic mul,
		input logic c, input byte_t a, input byte_t x, input byte_t b2,
		input byte_t b3, input addr_t pc);
		byte_t n, op, len;
		logic legal, has_ea;
		logic [15:0] prod;
		addr_t nxt;
		n = 8'h00;
		op = byte_t'($urandom);
		legal = (i < NUM_INSTR);
		has_ea = legal && !mul && m inside {AM_DIR, AM_EXT, AM_IX,
			AM_IX1, AM_IX2};
		len = exp_len(m, mul, i);
		prod = {8'h00, a} * {8'h00, x};
		mem.ram[pc] = op;
		mem.ram[pc + PC_STEP] = b2;
		mem.ram[pc + 13'h0002] = b3;
		@(posedge sys_clk);
		mode_in <= m;
		instr_idx <= i;
		is_mul <= mul;
		br_cond <= c;
		acc_in <= a;
		idx_in <= x;
		pc_in <= pc;
		pc_load <= 1'b1;
		@(posedge sys_clk);
		pc_load <= 1'b0;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		while (n < 8'h10) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n == 8'h01) cmp_b({7'h00, busy_ff}, 8'h01);
			if (done_ff === 1'b1) break;
		end
		cmp_b(n, len);
		cmp_b({7'h00, busy_ff}, 8'h00);
		cmp_b(opcode_ff, op);
		cmp_b({7'h00, illegal_ff}, {7'h00, !legal});
		cmp_b({7'h00, ea_vld_ff}, {7'h00, has_ea});
		if (has_ea) cmp_a(ea_ff, exp_ea(m, x, b2, b3));
		cmp_b({7'h00, imm_vld_ff}, {7'h00, legal && !mul && m == AM_IMM});
		if (legal && !mul && m == AM_IMM) cmp_b(imm_ff, b2);
		cmp_b({7'h00, ax_wr_ff}, {7'h00, legal && mul});
		if (legal && mul) cmp_b(acc_out_ff, prod[7:0]);
		if (legal && mul) cmp_b(idx_out_ff, prod[15:8]);
		nxt = pc + (mul ? PC_STEP : addr_t'((len - 8'h02) >> 1));
		if (m == AM_REL && c) nxt = nxt + {{5{b2[7]}}, b2};
		if (legal) cmp_a(pc_ff, nxt);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		am_e m;
		logic mul;
		void'($urandom(37));
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		run(AM_IX1, 6'h05, 1'b0, 1'b0, 8'h00, 8'hFF, 8'hFF, 8'h00, 13'h0100);
		run(AM_IX2, 6'h06, 1'b0, 1'b0, 8'h00, 8'hFF, 8'hFF, 8'hFF, 13'h0200);
		run(AM_EXT, 6'h07, 1'b0, 1'b0, 8'h00, 8'h11, 8'hFF, 8'h01, 13'h0300);
		run(AM_REL, 6'h08, 1'b0, 1'b1, 8'h00, 8'h00, 8'h80, 8'h00, 13'h0100);
		run(AM_REL, 6'h08, 1'b0, 1'b1, 8'h00, 8'h00, 8'h7F, 8'h00, 13'h1FFE);
		run(AM_REL, 6'h08, 1'b0, 1'b0, 8'h00, 8'h00, 8'h7F, 8'h00, 13'h0400);
		run(AM_DIR, 6'h3D, 1'b0, 1'b0, 8'h00, 8'hFF, 8'h80, 8'h00, 13'h0500);
		run(AM_INH, 6'h3E, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 13'h0600);
		run(AM_INH, 6'h3D, 1'b1, 1'b0, 8'hFF, 8'hFF, 8'h00, 8'h00, 13'h0700);
		for (int k = 0; k < 300; k++) begin
			m = am_e'(3'($urandom));
			mul = (m == AM_INH) && ($urandom_range(1, 0) == 1);
			run(m, instr_idx_t'($urandom), mul, 1'($urandom),
				byte_t'($urandom), byte_t'($urandom), byte_t'($urandom),
				byte_t'($urandom), addr_t'($urandom));
		end
		final_report();
	end

	// A hang counts against the run and still ends with the verdict.
	initial begin
		#200000;
		n_mismatch++;
		final_report();
	end
endmodule
